// ### rtl/msi_cap_defines.svh
// Register offsets, field positions, reset values and codes of the interrupt capability block
`ifndef MSI_CAP_DEFINES_SVH
`define MSI_CAP_DEFINES_SVH

`define OFS_MSI_CAP_CONTROL 8'hD0
`define OFS_MSI_DEST_LOW 8'hD4
`define OFS_MSI_DEST_HIGH 8'hD8
`define OFS_MSI_PAYLOAD 8'hDC
`define OFS_SUBSYS_CAP_HEADER 8'hF0
`define OFS_LOCK_CTRL 8'hE0
`define OFS_IRQ_STATUS 8'hE4
`define OFS_IRQ_ENABLE 8'hE8
`define OFS_IRQ_CLEAR 8'hEC

`define MSI_CAPABILITY_CODE 8'h05
`define SUBSYS_CAPABILITY_CODE 8'h0D
`define NEXT_LINK_RESET 8'h00
`define ENABLE_BIT 16
`define REQ_COUNT_LO 17
`define GRANT_COUNT_LO 20
`define WIDE_CAPABLE_BIT 23
`define REQ_COUNT_VALUE 3'h0
`define GRANT_COUNT_VALUE 3'h0
`define WIDE_CAPABLE_VALUE 1'h1
`define DEST_LOW_MASK 32'hFFFFFFFC
`define PAYLOAD_MASK 32'h0000FFFF

`define IRQ_SENT_BIT 0
`define IRQ_DROP_BIT 1
`define IRQ_BITS 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/msi_cap_pkg.sv
// Types of the interrupt capability block
`default_nettype none
package msi_cap_pkg;

	typedef enum logic [1:0]
	{
		MSG_IDLE = 2'h1,
		MSG_SEND = 2'h2
	} msg_state_e;

	typedef struct packed
	{
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [7:0] next_link;
		logic enable;
		logic [29:0] dest_low;
		logic [31:0] dest_high;
		logic [15:0] payload;
		logic [7:0] subsys_link;
		logic link_lock;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		msg_state_e state;
		logic [63:0] msg_addr;
		logic msg_wide;
		logic [31:0] msg_data;
	} state_s;

endpackage : msi_cap_pkg
`default_nettype wire

// ### rtl/msi_capability_block.sv
// Message signaled interrupt capability with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
`include "msi_cap_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module msi_capability_block
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_event,
	output logic msg_valid,
	input wire logic msg_ready,
	output logic [63:0] msg_addr,
	output logic msg_wide,
	output logic [31:0] msg_data,
	output logic irq
);

	msi_cap_pkg::state_s q, d;
	logic do_write;
	logic do_read;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;
	logic [1:0] ev;

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	assign s_axi_awready = !q.aw_full;
	assign s_axi_wready = !q.w_full;
	assign s_axi_arready = !q.r_valid;
	assign s_axi_bvalid = q.b_valid;
	assign s_axi_bresp = q.b_resp;
	assign s_axi_rvalid = q.r_valid;
	assign s_axi_rdata = q.r_data;
	assign s_axi_rresp = q.r_resp;
	assign msg_valid = (q.state == msi_cap_pkg::MSG_SEND);
	assign msg_addr = q.msg_addr;
	assign msg_wide = q.msg_wide;
	assign msg_data = q.msg_data;
	assign irq = |(q.irq_status & q.irq_enable);

	assign do_write = q.aw_full && q.w_full && !q.b_valid;
	assign do_read = s_axi_arvalid && !q.r_valid;
	assign wmask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};

	////////////////////////////////////////////////////////////////////////////////
	// Read and write decode

	always_comb
	begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`OFS_MSI_CAP_CONTROL:
			begin
				rd_word[7:0] = `MSI_CAPABILITY_CODE;
				rd_word[15:8] = q.next_link;
				rd_word[`ENABLE_BIT] = q.enable;
				rd_word[`REQ_COUNT_LO +: 3] = `REQ_COUNT_VALUE;
				rd_word[`GRANT_COUNT_LO +: 3] = `GRANT_COUNT_VALUE;
				rd_word[`WIDE_CAPABLE_BIT] = `WIDE_CAPABLE_VALUE;
			end
			`OFS_MSI_DEST_LOW: rd_word = {q.dest_low, 2'h0};
			`OFS_MSI_DEST_HIGH: rd_word = q.dest_high;
			`OFS_MSI_PAYLOAD: rd_word = {16'h0000, q.payload};
			`OFS_SUBSYS_CAP_HEADER: rd_word = {16'h0000, q.subsys_link, `SUBSYS_CAPABILITY_CODE};
			`OFS_LOCK_CTRL: rd_word = {31'h00000000, q.link_lock};
			`OFS_IRQ_STATUS: rd_word = {30'h00000000, q.irq_status};
			`OFS_IRQ_ENABLE: rd_word = {30'h00000000, q.irq_enable};
			`OFS_IRQ_CLEAR: rd_word = 32'h00000000;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		unique case (q.aw_addr)
			`OFS_MSI_CAP_CONTROL, `OFS_MSI_DEST_LOW, `OFS_MSI_DEST_HIGH, `OFS_MSI_PAYLOAD,
			`OFS_SUBSYS_CAP_HEADER, `OFS_LOCK_CTRL, `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE,
			`OFS_IRQ_CLEAR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		d = q;
		ev = 2'h0;

		if (s_axi_awvalid && !q.aw_full)
		begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_full)
		begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.b_valid && s_axi_bready)
			d.b_valid = 1'b0;

		if (do_write)
		begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.b_valid = 1'b1;
			d.b_resp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			unique case (q.aw_addr)
				`OFS_MSI_CAP_CONTROL:
				begin
					if (q.w_strb[1] && !q.link_lock)
						d.next_link = q.w_data[15:8];
					if (q.w_strb[2])
						d.enable = q.w_data[`ENABLE_BIT];
				end
				`OFS_MSI_DEST_LOW:
					d.dest_low = (q.w_data[31:2] & wmask[31:2]) | (q.dest_low & ~wmask[31:2]);
				`OFS_MSI_DEST_HIGH:
					d.dest_high = (q.w_data & wmask) | (q.dest_high & ~wmask);
				`OFS_MSI_PAYLOAD:
					d.payload = 16'((q.w_data & wmask & `PAYLOAD_MASK) | ({16'h0000, q.payload} & ~wmask));
				`OFS_SUBSYS_CAP_HEADER:
					if (q.w_strb[1] && !q.link_lock)
						d.subsys_link = q.w_data[15:8];
				`OFS_LOCK_CTRL:
					if (q.w_strb[0])
						d.link_lock = q.w_data[0];
				`OFS_IRQ_ENABLE:
					if (q.w_strb[0])
						d.irq_enable = q.w_data[1:0];
				`OFS_IRQ_CLEAR:
					if (q.w_strb[0])
						d.irq_status = q.irq_status & ~q.w_data[1:0];
				default:
				begin
				end
			endcase
		end

		if (q.r_valid && s_axi_rready)
			d.r_valid = 1'b0;
		if (do_read)
		begin
			d.r_valid = 1'b1;
			d.r_data = rd_word;
			d.r_resp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end

		// Message generator
		unique case (q.state)
			msi_cap_pkg::MSG_IDLE:
				if (irq_event)
				begin
					if (q.enable)
					begin
						d.state = msi_cap_pkg::MSG_SEND;
						d.msg_wide = (q.dest_high != 32'h00000000);
						d.msg_addr = d.msg_wide ? {q.dest_high, q.dest_low, 2'h0}
							: {32'h00000000, q.dest_low, 2'h0};
						d.msg_data = {16'h0000, q.payload};
						ev[`IRQ_SENT_BIT] = 1'b1;
					end
					else
						ev[`IRQ_DROP_BIT] = 1'b1;
				end
			msi_cap_pkg::MSG_SEND:
			begin
				if (irq_event)
					ev[`IRQ_DROP_BIT] = 1'b1;
				if (msg_ready)
					d.state = msi_cap_pkg::MSG_IDLE;
			end
		endcase

		// Set wins over clear
		d.irq_status = d.irq_status | ev;

		if (rst)
		begin
			d = '0;
			d.next_link = `NEXT_LINK_RESET;
			d.subsys_link = `NEXT_LINK_RESET;
			d.state = msi_cap_pkg::MSG_IDLE;
		end
	end

	always_ff @(posedge core_clk)
		q <= d;

endmodule : msi_capability_block

`default_nettype wire

// ### dv/msi_cap_asserts.sv
// Port assertions of the interrupt capability block
`timescale 1ns/1ns
`default_nettype none
module msi_cap_asserts
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic irq_event,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire logic [63:0] msg_addr,
	input wire logic msg_wide,
	input wire logic [31:0] msg_data
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence rd_at(logic [7:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a ##1 s_axi_rvalid;
	endsequence
	a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr))
		else $error("message lost");
	a_wide_sel: assert property (msg_valid |-> msg_wide == (msg_addr[63:32] != 32'h0))
		else $error("bad width");
	a_addr_align: assert property (msg_valid |-> msg_addr[1:0] == 2'h0)
		else $error("bad align");
	a_data_upper: assert property (msg_valid |-> msg_data[31:16] == 16'h0)
		else $error("bad data");
	a_msg_cause: assert property ($rose(msg_valid) |-> $past(irq_event))
		else $error("no cause");
	a_msg_done: assert property (msg_valid && msg_ready |=> !msg_valid)
		else $error("repeat");
	a_cap_code: assert property (rd_at(8'hD0) |-> s_axi_rdata[7:0] == 8'h05 && s_axi_rdata[23:17] == 7'h40)
		else $error("bad header");
	a_sub_code: assert property (rd_at(8'hF0) |-> s_axi_rdata[7:0] == 8'h0D && s_axi_rdata[31:16] == 16'h0)
		else $error("bad sub header");
endmodule : msi_cap_asserts
`default_nettype wire

// ### dv/msi_root_model.sv
// Root side model taking interrupt writes
`timescale 1ns/1ns
`default_nettype none
module msi_root_model
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic msg_valid,
	output logic msg_ready = 1'h0,
	output logic [7:0] msg_count
);
	// Random stalls, one count per write
	always @(posedge core_clk)
	begin
		msg_ready <= !rst && $urandom_range(2) != 0;
		if (rst)
			msg_count <= 8'h00;
		else if (msg_valid && msg_ready)
			msg_count <= msg_count + 8'h01;
	end
endmodule : msi_root_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the interrupt capability block
`timescale 1ns/1ns
`default_nettype none
`include "msi_cap_defines.svh"
module tb_top;
	logic core_clk = 1'h0, rst = 1'h1, irq_event = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, msg_count;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, msg_data, lo, hi, pay;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, msg_valid, msg_ready, msg_wide, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [63:0] msg_addr;
	logic [96:0] q[$];
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	msi_capability_block u_msi_capability_block (.*);
	msi_root_model u_msi_root_model (.*);
	always #5 core_clk = ~core_clk;
	task automatic chk(input logic [96:0] got, input logic [96:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			error_cnt++;
			give_verdict();
		end
		if (s_axi_bvalid && s_axi_bready)
			chk({95'h0, s_axi_bresp}, q.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			chk({63'h0, s_axi_rresp, s_axi_rdata}, q.pop_front());
		if (msg_valid && msg_ready)
			chk({msg_wide, msg_addr, msg_data}, q.pop_front());
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input logic [3:0] s = 4'hF);
		q.push_back({95'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid || s_axi_wvalid);
		do @(posedge core_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
		q.push_back({63'h0, r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge core_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		@(posedge core_clk);
	endtask : rd
	task automatic ev(input logic on);
		if (on) q.push_back({hi != 32'h0, hi, lo & `DEST_LOW_MASK, 16'h0, pay[15:0]});
		irq_event <= 1'h1;
		@(posedge core_clk);
		irq_event <= 1'h0;
		repeat (2) @(posedge core_clk);
		while (msg_valid) @(posedge core_clk);
	endtask : ev
	initial
	begin
		void'($urandom(32'h7511));
		repeat (5) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		rd(`OFS_MSI_CAP_CONTROL, 32'h0080_0005);
		rd(`OFS_SUBSYS_CAP_HEADER, 32'h0000_000D);
		rd(`OFS_MSI_DEST_HIGH, 32'h0);
		wr(`OFS_MSI_CAP_CONTROL, 32'hFFFF_FFFF, `RESP_OKAY);
		rd(`OFS_MSI_CAP_CONTROL, 32'h0081_FF05);
		wr(`OFS_MSI_CAP_CONTROL, 32'h0, `RESP_OKAY, 4'hB);
		rd(`OFS_MSI_CAP_CONTROL, 32'h0081_0005);
		wr(`OFS_SUBSYS_CAP_HEADER, 32'hFFFF_FFFF, `RESP_OKAY);
		wr(`OFS_LOCK_CTRL, 32'h1, `RESP_OKAY);
		wr(`OFS_SUBSYS_CAP_HEADER, 32'h0, `RESP_OKAY);
		rd(`OFS_SUBSYS_CAP_HEADER, 32'h0000_FF0D);
		wr(`OFS_IRQ_ENABLE, 32'h3, `RESP_OKAY);
		$display("register test done");
		for (int i = 0; i < 4; i++)
		begin
			lo = $urandom;
			hi = i[0] ? ($urandom | 32'h1) : 32'h0;
			pay = $urandom;
			wr(`OFS_MSI_DEST_LOW, lo, `RESP_OKAY);
			wr(`OFS_MSI_DEST_HIGH, hi, `RESP_OKAY);
			wr(`OFS_MSI_PAYLOAD, pay, `RESP_OKAY);
			rd(`OFS_MSI_DEST_LOW, lo & `DEST_LOW_MASK);
			rd(`OFS_MSI_PAYLOAD, pay & `PAYLOAD_MASK);
			ev(1'h1);
		end
		$display("message test done");
		rd(`OFS_IRQ_STATUS, 32'h1);
		chk({96'h0, irq}, 97'h1);
		wr(`OFS_MSI_CAP_CONTROL, 32'h0, `RESP_OKAY);
		ev(1'h0);
		rd(`OFS_IRQ_STATUS, 32'h3);
		wr(`OFS_IRQ_ENABLE, 32'h0, `RESP_OKAY);
		chk({96'h0, irq}, 97'h0);
		wr(`OFS_IRQ_CLEAR, 32'h3, `RESP_OKAY);
		wr(`OFS_IRQ_ENABLE, 32'h3, `RESP_OKAY);
		chk({96'h0, irq}, 97'h0);
		rd(8'h40, 32'h0, `RESP_SLVERR);
		wr(8'h40, 32'h1, `RESP_SLVERR);
		chk({89'h0, msg_count}, 97'h4);
		$display("interrupt test done");
		give_verdict();
	end
endmodule : tb_top
bind msi_capability_block msi_cap_asserts u_msi_cap_asserts (.*);
`default_nettype wire
